// >>> src/cnmt_defines.vh
`ifndef CNMT_DEFINES_VH
`define CNMT_DEFINES_VH

// ----------------------------------------
// Function codes (identifier bits 10:7)
// ----------------------------------------
`define CNMT_FC_NMT 4'h0
`define CNMT_FC_SYNC_EMCY 4'h1
`define CNMT_FC_TPDO1 4'h3
`define CNMT_FC_RPDO1 4'h4
`define CNMT_FC_TPDO2 4'h5
`define CNMT_FC_RPDO2 4'h6
`define CNMT_FC_TPDO3 4'h7
`define CNMT_FC_RPDO3 4'h8
`define CNMT_FC_TPDO4 4'h9
`define CNMT_FC_RPDO4 4'hA
`define CNMT_FC_SDO_TX 4'hB
`define CNMT_FC_SDO_RX 4'hC
`define CNMT_FC_GUARD 4'hE
`define CNMT_ID_FC_HI 10
`define CNMT_ID_FC_LO 7
`define CNMT_ID_NODE_HI 6
`define CNMT_ID_NMT 11'h000
`define CNMT_ID_SYNC 11'h080

// ----------------------------------------
// Identifier classes
// ----------------------------------------
`define CNMT_CLS_NONE 4'h0
`define CNMT_CLS_NMT 4'h1
`define CNMT_CLS_SYNC 4'h2
`define CNMT_CLS_EMCY 4'h3
`define CNMT_CLS_TPDO 4'h4
`define CNMT_CLS_RPDO 4'h5
`define CNMT_CLS_SDO_TX 4'h6
`define CNMT_CLS_SDO_RX 4'h7
`define CNMT_CLS_GUARD 4'h8

// ----------------------------------------
// Management command specifiers
// ----------------------------------------
`define CNMT_CMD_START 8'h01
`define CNMT_CMD_STOP 8'h02
`define CNMT_CMD_PREOP 8'h80
`define CNMT_CMD_RST_NODE 8'h81
`define CNMT_CMD_RST_COMM 8'h82

// ----------------------------------------
// Node state codes on the state output
// ----------------------------------------
`define CNMT_ST_INIT 8'h00
`define CNMT_ST_STOPPED 8'h04
`define CNMT_ST_OPER 8'h05
`define CNMT_ST_PREOP 8'h7F

// ----------------------------------------
// Index range reset in reset-communication
// ----------------------------------------
`define CNMT_COMM_IDX_FIRST 16'h1000
`define CNMT_COMM_IDX_LAST 16'h1FFF

`endif

// >>> src/cnmt_id_class.v
`timescale 1ns/1ps
`default_nettype none
`include "cnmt_defines.vh"

// Registered identifier classifier
module cnmt_id_class #(
    parameter [6:0] NODE_ID = 7'h01
) (
    input wire mclk,
    input wire rst,
    input wire rx_valid,
    input wire [10:0] rx_id,
    output reg cls_valid_q,
    output reg [3:0] cls_q,
    output reg for_me_q
);
    wire [3:0] fc = rx_id[`CNMT_ID_FC_HI:`CNMT_ID_FC_LO];
    wire [6:0] nd = rx_id[`CNMT_ID_NODE_HI:0];
    reg [3:0] cls_d;

    always @* begin
        cls_d = `CNMT_CLS_NONE;
        case (fc)
            `CNMT_FC_NMT: cls_d = (nd == 7'h00) ? `CNMT_CLS_NMT : `CNMT_CLS_NONE;
            `CNMT_FC_SYNC_EMCY: cls_d = (nd == 7'h00) ? `CNMT_CLS_SYNC : `CNMT_CLS_EMCY;
            `CNMT_FC_TPDO1, `CNMT_FC_TPDO2, `CNMT_FC_TPDO3, `CNMT_FC_TPDO4:
                cls_d = (nd != 7'h00) ? `CNMT_CLS_TPDO : `CNMT_CLS_NONE;
            `CNMT_FC_RPDO1, `CNMT_FC_RPDO2, `CNMT_FC_RPDO3, `CNMT_FC_RPDO4:
                cls_d = (nd != 7'h00) ? `CNMT_CLS_RPDO : `CNMT_CLS_NONE;
            `CNMT_FC_SDO_TX: cls_d = (nd != 7'h00) ? `CNMT_CLS_SDO_TX : `CNMT_CLS_NONE;
            `CNMT_FC_SDO_RX: cls_d = (nd != 7'h00) ? `CNMT_CLS_SDO_RX : `CNMT_CLS_NONE;
            `CNMT_FC_GUARD: cls_d = (nd != 7'h00) ? `CNMT_CLS_GUARD : `CNMT_CLS_NONE;
            default: cls_d = `CNMT_CLS_NONE;
        endcase
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cls_valid_q <= 1'b0;
            cls_q <= 4'h0;
            for_me_q <= 1'b0;
        end else begin
            cls_valid_q <= rx_valid;
            cls_q <= cls_d;
            for_me_q <= (nd == NODE_ID) || (cls_d == `CNMT_CLS_NMT) ||
                        (cls_d == `CNMT_CLS_SYNC);
        end
    end
endmodule

`default_nettype wire

// >>> src/cnmt_state_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "cnmt_defines.vh"

module cnmt_state_ctrl #(
    parameter [6:0] NODE_ID = 7'h01
) (
    input wire mclk,
    input wire rst,
    input wire rx_valid,
    input wire [10:0] rx_id,
    input wire [7:0] rx_byte0,
    input wire [7:0] rx_byte1,
    input wire app_init_done,
    input wire comm_init_done,
    input wire can_cfg_done,
    input wire bootup_ack,
    output reg app_init_start_q,
    output reg comm_init_start_q,
    output reg [15:0] comm_idx_first_q,
    output reg [15:0] comm_idx_last_q,
    output reg can_cfg_start_q,
    output reg bootup_req_q,
    output reg [10:0] bootup_id_q,
    output reg [7:0] node_state_q,
    output reg pdo_en_q,
    output reg sdo_en_q,
    output reg emcy_en_q,
    output reg nmt_en_q,
    output reg guard_en_q,
    output reg rx_pdo_q,
    output reg rx_sdo_q,
    output reg rx_sync_q,
    output reg rx_guard_q
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [5:0] S_RST_APP = 6'b000001;
    localparam [5:0] S_RST_COMM = 6'b000010;
    localparam [5:0] S_INIT = 6'b000100;
    localparam [5:0] S_PREOP = 6'b001000;
    localparam [5:0] S_OPER = 6'b010000;
    localparam [5:0] S_STOP = 6'b100000;

    // ----------------------------------------
    // State group decoding
    // ----------------------------------------
    // Pre-operational or operational: service data and emergency allowed
    function f_svc_ok;
        input [5:0] s;
        begin
            f_svc_ok = (s == S_PREOP) || (s == S_OPER);
        end
    endfunction

    // Past init: management and monitoring stay alive
    function f_running;
        input [5:0] s;
        begin
            f_running = (s == S_PREOP) || (s == S_OPER) || (s == S_STOP);
        end
    endfunction

    // High on the edge that moves the node into state s
    function f_enter;
        input [5:0] nxt;
        input [5:0] cur;
        input [5:0] s;
        begin
            f_enter = (nxt == s) && (cur != s);
        end
    endfunction

    // Code shown on the state output
    function [7:0] f_state_code;
        input [5:0] s;
        begin
            case (s)
                S_PREOP: f_state_code = `CNMT_ST_PREOP;
                S_OPER: f_state_code = `CNMT_ST_OPER;
                S_STOP: f_state_code = `CNMT_ST_STOPPED;
                default: f_state_code = `CNMT_ST_INIT;
            endcase
        end
    endfunction

    reg [5:0] st_q, st_d;
    reg started_q;
    reg boot_pend_q, boot_pend_d;

    wire cls_valid;
    wire [3:0] cls;
    wire for_me;
    reg [7:0] cmd_q, node_q;

    cnmt_id_class #(.NODE_ID(NODE_ID)) u_cls (
        .mclk(mclk),
        .rst(rst),
        .rx_valid(rx_valid),
        .rx_id(rx_id),
        .cls_valid_q(cls_valid),
        .cls_q(cls),
        .for_me_q(for_me)
    );

    // Command bytes aligned with the registered class
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmd_q <= 8'h00;
            node_q <= 8'h00;
        end else begin
            cmd_q <= rx_byte0;
            node_q <= rx_byte1;
        end
    end

    // Management command addressed to this node or broadcast
    wire nmt_hit = cls_valid && (cls == `CNMT_CLS_NMT) &&
                   ((node_q == 8'h00) || (node_q == {1'b0, NODE_ID}));
    wire c_start = nmt_hit && (cmd_q == `CNMT_CMD_START);
    wire c_stop = nmt_hit && (cmd_q == `CNMT_CMD_STOP);
    wire c_preop = nmt_hit && (cmd_q == `CNMT_CMD_PREOP);
    wire c_rnode = nmt_hit && (cmd_q == `CNMT_CMD_RST_NODE);
    wire c_rcomm = nmt_hit && (cmd_q == `CNMT_CMD_RST_COMM);
    wire running = f_running(st_q);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always @* begin
        st_d = st_q;
        boot_pend_d = boot_pend_q && !bootup_ack;
        case (st_q)
            S_RST_APP: begin
                if (app_init_done && started_q) st_d = S_RST_COMM;
            end
            S_RST_COMM: begin
                if (comm_init_done && started_q) st_d = S_INIT;
            end
            S_INIT: begin
                if (can_cfg_done && started_q) begin
                    st_d = S_PREOP;
                    boot_pend_d = 1'b1;
                end
            end
            S_PREOP: begin
                if (c_start) st_d = S_OPER;
                else if (c_stop) st_d = S_STOP;
            end
            S_OPER: begin
                if (c_stop) st_d = S_STOP;
                else if (c_preop) st_d = S_PREOP;
            end
            S_STOP: begin
                if (c_start) st_d = S_OPER;
                else if (c_preop) st_d = S_PREOP;
            end
            default: st_d = S_RST_APP;
        endcase
        // Any other command leaves the state as it was
        if (running && c_rnode) begin
            st_d = S_RST_APP;
            boot_pend_d = 1'b0;
        end else if (running && c_rcomm) begin
            st_d = S_RST_COMM;
            boot_pend_d = 1'b0;
        end
    end

    // ----------------------------------------
    // State and outputs
    // ----------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q <= S_RST_APP;
            started_q <= 1'b0;
            boot_pend_q <= 1'b0;
            app_init_start_q <= 1'b0;
            comm_init_start_q <= 1'b0;
            comm_idx_first_q <= 16'h0000;
            comm_idx_last_q <= 16'h0000;
            can_cfg_start_q <= 1'b0;
            bootup_req_q <= 1'b0;
            bootup_id_q <= 11'h000;
            node_state_q <= `CNMT_ST_INIT;
            pdo_en_q <= 1'b0;
            sdo_en_q <= 1'b0;
            emcy_en_q <= 1'b0;
            nmt_en_q <= 1'b0;
            guard_en_q <= 1'b0;
            rx_pdo_q <= 1'b0;
            rx_sdo_q <= 1'b0;
            rx_sync_q <= 1'b0;
            rx_guard_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
            st_q <= st_d;
            boot_pend_q <= boot_pend_d;
            // One-cycle starts on entry to each reset / init phase
            app_init_start_q <= (st_d == S_RST_APP) && (st_q != S_RST_APP || !started_q);
            comm_init_start_q <= f_enter(st_d, st_q, S_RST_COMM);
            comm_idx_first_q <= `CNMT_COMM_IDX_FIRST;
            comm_idx_last_q <= `CNMT_COMM_IDX_LAST;
            can_cfg_start_q <= f_enter(st_d, st_q, S_INIT);
            bootup_req_q <= boot_pend_d;
            bootup_id_q <= {`CNMT_FC_GUARD, NODE_ID};
            node_state_q <= f_state_code(st_d);
            pdo_en_q <= (st_d == S_OPER);
            sdo_en_q <= f_svc_ok(st_d);
            emcy_en_q <= f_svc_ok(st_d);
            nmt_en_q <= f_running(st_d);
            guard_en_q <= f_running(st_d);
            // Accepted receive strobes gated by the current state
            rx_pdo_q <= cls_valid && for_me && pdo_en_q &&
                        (cls == `CNMT_CLS_RPDO);
            rx_sdo_q <= cls_valid && for_me && sdo_en_q &&
                        (cls == `CNMT_CLS_SDO_RX);
            rx_sync_q <= cls_valid && pdo_en_q && (cls == `CNMT_CLS_SYNC);
            rx_guard_q <= cls_valid && for_me && guard_en_q &&
                          (cls == `CNMT_CLS_GUARD);
        end
    end
endmodule

`default_nettype wire

// >>> testbench/cnmt_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Network master: frames and boot-up ack
// ----------------------------------------
module cnmt_master_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic send,
    input wire logic [10:0] id,
    input wire logic [7:0] b0,
    input wire logic [7:0] b1,
    input wire logic [3:0] ack_dly,
    input wire logic bootup_req,
    output logic rx_valid,
    output logic [10:0] rx_id,
    output logic [7:0] rx_byte0,
    output logic [7:0] rx_byte1,
    output logic bootup_ack
);
    logic [3:0] cnt_q;
    // Idle fields toggle so stale values are never mistaken for a frame
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_valid <= 1'b0;
            rx_id <= 11'h000;
            rx_byte0 <= 8'h00;
            rx_byte1 <= 8'h00;
            cnt_q <= 4'h0;
            bootup_ack <= 1'b0;
        end else begin
            rx_valid <= send;
            rx_id <= send ? id : ~rx_id;
            rx_byte0 <= send ? b0 : ~rx_byte0;
            rx_byte1 <= send ? b1 : ~rx_byte1;
            cnt_q <= bootup_req ? cnt_q + 4'h1 : 4'h0;
            bootup_ack <= bootup_req && cnt_q == ack_dly;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/cnmt_state_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "cnmt_defines.vh"
module cnmt_chk #(
    parameter [6:0] NODE_ID = 7'h01
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic [10:0] rx_id,
    input wire logic [7:0] rx_byte0,
    input wire logic [7:0] rx_byte1,
    input wire logic bootup_req_q,
    input wire logic [7:0] node_state_q,
    input wire logic pdo_en_q,
    input wire logic sdo_en_q,
    input wire logic emcy_en_q,
    input wire logic app_init_start_q,
    input wire logic comm_init_start_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire nmt = rx_valid && rx_id == 11'h000 && (rx_byte1 == 8'h00 || rx_byte1 == {1'b0, NODE_ID});
    wire pre = node_state_q == `CNMT_ST_PREOP;
    wire opr = node_state_q == `CNMT_ST_OPER;
    wire stp = node_state_q == `CNMT_ST_STOPPED;
    a_pdo_oper_only: assert property (pdo_en_q == opr)
        else $error("pdo enable wrong");
    a_sdo_state: assert property (sdo_en_q == (pre || opr))
        else $error("sdo enable wrong");
    a_emcy_state: assert property (emcy_en_q == (pre || opr))
        else $error("emcy enable wrong");
    a_start_to_oper: assert property (nmt && rx_byte0 == 8'h01 && (pre || stp) |-> ##2 opr)
        else $error("start not taken");
    a_stop_to_stopped: assert property (nmt && rx_byte0 == 8'h02 && (pre || opr) |-> ##2 stp)
        else $error("stop not taken");
    a_preop_cmd: assert property (nmt && rx_byte0 == 8'h80 && (opr || stp) |-> ##2 pre)
        else $error("pre-op not taken");
    a_bad_cmd_kept: assert property (nmt && rx_byte0 == 8'h02 && stp |-> ##2 stp)
        else $error("invalid command moved state");
    a_reset_node: assert property (nmt && rx_byte0 == 8'h81 && (pre || opr || stp)
        |-> ##2 node_state_q == `CNMT_ST_INIT ##[0:1] app_init_start_q)
        else $error("reset node not taken");
    a_reset_comm: assert property (nmt && rx_byte0 == 8'h82 && (pre || opr || stp)
        |-> ##2 node_state_q == `CNMT_ST_INIT ##[0:1] comm_init_start_q)
        else $error("reset comm not taken");
    a_bootup_entry: assert property ($rose(bootup_req_q) |-> pre && $past(node_state_q) == 8'h00)
        else $error("boot-up outside init exit");
endmodule
bind cnmt_state_ctrl cnmt_chk #(.NODE_ID(NODE_ID)) u_chk (.mclk(mclk), .rst(rst),
    .rx_valid(rx_valid), .rx_id(rx_id), .rx_byte0(rx_byte0), .rx_byte1(rx_byte1),
    .bootup_req_q(bootup_req_q), .node_state_q(node_state_q), .pdo_en_q(pdo_en_q),
    .sdo_en_q(sdo_en_q), .emcy_en_q(emcy_en_q), .app_init_start_q(app_init_start_q),
    .comm_init_start_q(comm_init_start_q));
`default_nettype wire

// >>> testbench/tb_canopen_slave_network_state_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_canopen_slave_network_state_control;
    logic mclk = 0, rst = 1, send = 0, app_d = 0, comm_d = 0, cfg_d = 0, ack, rxv;
    logic [10:0] id = 0, rxid, bid;
    logic [7:0] b0 = 0, b1 = 0, rb0, rb1, st;
    logic [3:0] dly = 1, seen;
    logic [15:0] ifirst, ilast;
    logic as, cs, gs, breq, pdo, sdo, emcy, nmte, grde, rpdo, rsdo, rsync, rgrd;
    int n_errors = 0, checks_done = 0, cyc = 0;
    logic [26:0] rows [10] = '{{8'h01, 8'h01, 8'h05, 3'b111}, {8'h80, 8'h01, 8'h7F, 3'b011},
        {8'h02, 8'h01, 8'h04, 3'b000}, {8'h02, 8'h01, 8'h04, 3'b000},
        {8'h01, 8'h00, 8'h05, 3'b111}, {8'h02, 8'h01, 8'h04, 3'b000},
        {8'h80, 8'h01, 8'h7F, 3'b011}, {8'h01, 8'h05, 8'h7F, 3'b011},
        {8'h80, 8'h01, 8'h7F, 3'b011}, {8'h02, 8'h00, 8'h04, 3'b000}};
    always #12.5 mclk = ~mclk;
    cnmt_master_model u_master (.mclk(mclk), .rst(rst), .send(send), .id(id), .b0(b0), .b1(b1),
        .ack_dly(dly), .bootup_req(breq), .rx_valid(rxv), .rx_id(rxid), .rx_byte0(rb0),
        .rx_byte1(rb1), .bootup_ack(ack));
    cnmt_state_ctrl uut (.mclk(mclk), .rst(rst), .rx_valid(rxv), .rx_id(rxid), .rx_byte0(rb0),
        .rx_byte1(rb1), .app_init_done(app_d), .comm_init_done(comm_d), .can_cfg_done(cfg_d),
        .bootup_ack(ack), .app_init_start_q(as), .comm_init_start_q(cs),
        .comm_idx_first_q(ifirst), .comm_idx_last_q(ilast), .can_cfg_start_q(gs),
        .bootup_req_q(breq), .bootup_id_q(bid), .node_state_q(st), .pdo_en_q(pdo),
        .sdo_en_q(sdo), .emcy_en_q(emcy), .nmt_en_q(nmte), .guard_en_q(grde),
        .rx_pdo_q(rpdo), .rx_sdo_q(rsdo), .rx_sync_q(rsync), .rx_guard_q(rgrd));
    // Local application answers each start pulse one cycle later
    always @(posedge mclk) begin
        app_d <= as;
        comm_d <= cs;
        cfg_d <= gs;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            $display("[ERR] %0t timeout", $time);
            test_done;
        end
    end
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic frame(input logic [10:0] i, input logic [7:0] c, input logic [7:0] n);
        @(posedge mclk) #1;
        send = 1; id = i; b0 = c; b1 = n;
        @(posedge mclk) #1;
        send = 0;
        seen = 0;
        repeat (5) @(posedge mclk) #1 seen = seen | {rpdo, rsdo, rsync, rgrd};
    endtask
    task automatic boot(input logic [3:0] d);
        dly = d;
        for (int k = 0; k < 60 && st !== 8'h7F; k++) @(posedge mclk) #1;
        `CHK(st, 8'h7F)
        `CHK({breq, bid, ifirst, ilast}, {1'b1, 11'h701, 16'h1000, 16'h1FFF})
        `CHK({pdo, sdo, emcy, nmte, grde}, 5'b01111)
        repeat (d + 4) @(posedge mclk) #1;
        `CHK(breq, 1'b0)
    endtask
    initial begin
        repeat (12) @(posedge mclk) #1;
        `CHK(st, 8'h00)
        `CHK({as, cs, gs, breq, pdo, sdo, emcy, nmte, grde, rpdo, rsdo, rsync, rgrd}, 13'h0000)
        rst = 0;
        boot(1);
        foreach (rows[r]) begin
            frame(11'h000, rows[r][26:19], rows[r][18:11]);
            `CHK({st, pdo, sdo, emcy}, rows[r][10:0])
        end
        frame(11'h701, 8'h00, 8'h00);
        `CHK(seen, 4'b0001)
        frame(11'h601, 8'h40, 8'h00);
        `CHK({seen, nmte, grde}, 6'b000011)
        frame(11'h000, 8'h82, 8'h01);
        boot(7);
        frame(11'h201, 8'h00, 8'h00);
        `CHK(seen, 4'b0000)
        frame(11'h601, 8'h40, 8'h00);
        `CHK(seen, 4'b0100)
        frame(11'h000, 8'h01, 8'h01);
        frame(11'h201, 8'h00, 8'h00);
        `CHK(seen, 4'b1000)
        frame(11'h080, 8'h00, 8'h00);
        `CHK(seen, 4'b0010)
        @(posedge mclk) #1;
        send = 1; id = 11'h000; b0 = 8'h02; b1 = 8'h01;
        @(posedge mclk) #1 b0 = 8'h80;
        @(posedge mclk) #1 send = 0;
        repeat (4) @(posedge mclk) #1;
        `CHK(st, 8'h7F)
        frame(11'h000, 8'h81, 8'h01);
        boot(3);
        test_done;
    end
endmodule
`default_nettype wire
